// File: see_slave.sv
/*
 Two-wire serial memory slave: address match, byte array, read-only identifier.
 Assumes the pads resolve the open-drain data wire and apply pull-downs to
 straps and write lock; scl and sda arrive unsynchronised from the bus master.
*/
// Function
// R1: Three strap inputs form part of the bus address, eight devices per bus.
// R2: Answer only when sent address bits equal strap levels; otherwise stay passive.
// R3: Undriven strap and write-lock inputs read as low.
// R4: Data line driven open-drain only: pull low or release.
// R5: Incoming bits captured on rising serial clock edges.
// R6: Outgoing bit changes only after a falling serial clock edge.
// R7: Master holds serial clock high while the bus is idle.
// R8: Write lock high blocks every write to the whole array.
// R9: Write lock low lets writes to the array proceed normally.
// R10: User array of byte-wide locations, 256 in this build.
// R11: 128-bit identifier can never be altered by any bus operation.
// R12: Identifier lives in its own space, apart from the user array.
// R13: Straps compared with the three bits after the type prefix.
`timescale 1ns/1ps
module see_slave
    import see_pkg::*;
#(
    parameter logic [ID_BYTES*BYTE_W-1:0] ID_VALUE = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic scl,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    input  wire logic chip_select_strap_0,
    input  wire logic chip_select_strap_1,
    input  wire logic chip_select_strap_2,
    input  wire logic write_lock,
    output logic      selected
);

    // ID_VALUE default is arbitrary; each part gets its own at build time
    localparam see_id_t ID_TABLE = ID_VALUE; // see R11, R12

    see_state_t         s_q;
    see_state_t         s_d;
    logic [SYNC_W-1:0]  pins_raw;
    logic [SYNC_W-1:0]  pins_s;
    logic               scl_s;
    logic               sda_s;
    logic               wp_s;
    logic [STRAP_W-1:0] strap_s;
    logic               scl_rise;
    logic               scl_fall;
    logic               start_cond;
    logic               stop_cond;
    logic [ADDR_W-1:0]  addr_inc;
    logic [BYTE_W-1:0]  rd_byte;
    logic [BYTE_W-1:0]  nx_byte;
    logic [3:0]         pfx;
    logic               pfx_ok;
    logic               strap_ok;
    logic               wr_ok;

    // All pins pass two flops before use
    assign pins_raw = {write_lock, chip_select_strap_2, chip_select_strap_1,
                       chip_select_strap_0, sda_i, scl};

    see_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .d      (pins_raw),
        .q      (pins_s)
    );

    // Synchronised pins; the pad pull-downs cover open pins, reset only starts them low, see R3
    assign scl_s   = pins_s[0];
    assign sda_s   = pins_s[1];
    assign strap_s = pins_s[4:2];
    assign wp_s    = pins_s[5];

    // Edge and bus-condition detection on the sampled wires
    assign scl_rise   = scl_s & ~s_q.scl_prev;
    assign scl_fall   = ~scl_s & s_q.scl_prev;
    assign start_cond = scl_s & s_q.scl_prev & s_q.sda_prev & ~sda_s;
    assign stop_cond  = scl_s & s_q.scl_prev & ~s_q.sda_prev & sda_s;

    // Read path: identifier space is separate from the array, see R12
    assign addr_inc = s_q.addr + 8'h01;
    assign rd_byte  = s_q.id_sel ? ID_TABLE[s_q.addr[ID_IDX_W-1:0]] : s_q.mem[s_q.addr];
    assign nx_byte  = s_q.id_sel ? ID_TABLE[addr_inc[ID_IDX_W-1:0]] : s_q.mem[addr_inc];

    // Address byte decode
    assign pfx      = s_q.shreg[PFX_MSB:PFX_LSB];
    assign pfx_ok   = (pfx == MEM_PREFIX) || (pfx == ID_PREFIX);
    assign strap_ok = (s_q.shreg[STRAP_MSB:STRAP_LSB] == strap_s); // see R1, R13

    // Identifier is never writable; lock covers the whole array, see R8, R9, R11
    assign wr_ok = ~wp_s & ~s_q.id_sel;

    // Protocol engine; start and stop override any bit in flight
    always_comb begin
        s_d          = s_q;
        s_d.scl_prev = scl_s;
        s_d.sda_prev = sda_s;
        if (start_cond) begin
            s_d.st      = ST_ADDR;
            s_d.bit_cnt = CNT_RST;
            s_d.oe      = 1'b0;
            s_d.sel     = 1'b0;
        end else if (stop_cond) begin
            s_d.st  = ST_IDLE;
            s_d.oe  = 1'b0;
            s_d.sel = 1'b0;
        end else begin
            unique case (s_q.st)
                ST_IDLE: begin
                    s_d.oe = 1'b0;
                end
                ST_ADDR, ST_WORD, ST_WDATA: begin
                    if (scl_rise) begin
                        // Sample on rising clock, see R5
                        s_d.shreg   = {s_q.shreg[BYTE_W-2:0], sda_s};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end else if (scl_fall && (s_q.bit_cnt == BIT_LAST)) begin
                        if (s_q.st == ST_ADDR) begin
                            if (pfx_ok && strap_ok) begin // see R2
                                s_d.oe     = 1'b1;
                                s_d.sel    = 1'b1;
                                s_d.id_sel = (pfx == ID_PREFIX);
                                s_d.rw     = s_q.shreg[RW_BIT];
                                s_d.st     = ST_ADDR_ACK;
                            end else begin
                                // Not ours: stay off the wire, see R2
                                s_d.st = ST_IDLE;
                            end
                        end else if (s_q.st == ST_WORD) begin
                            s_d.addr = s_q.id_sel ? {4'h0, s_q.shreg[ID_IDX_W-1:0]}
                                                  : s_q.shreg;
                            s_d.oe   = 1'b1;
                            s_d.st   = ST_WORD_ACK;
                        end else begin
                            if (wr_ok) begin
                                s_d.mem[s_q.addr] = s_q.shreg; // see R9, R10
                            end
                            // Refused bytes are not acknowledged, see R8, R11
                            s_d.oe   = wr_ok;
                            s_d.addr = addr_inc;
                            s_d.st   = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_WORD_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        // Release after the ack clock, see R6
                        s_d.oe      = 1'b0;
                        s_d.bit_cnt = CNT_RST;
                        if (s_q.st == ST_ADDR_ACK) begin
                            if (s_q.rw) begin
                                s_d.st = ST_RDATA;
                                s_d.oe = ~rd_byte[BYTE_W-1]; // see R4, R6
                            end else begin
                                s_d.st = ST_WORD;
                            end
                        end else begin
                            s_d.st = ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s_q.bit_cnt == BIT_LAST) begin
                            s_d.oe = 1'b0;
                            s_d.st = ST_MACK;
                        end else begin
                            // Next bit only after falling clock, see R4, R6
                            s_d.oe = ~rd_byte[~s_q.bit_cnt[2:0]];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        s_d.m_ack = ~sda_s; // see R5
                    end else if (scl_fall) begin
                        s_d.addr    = addr_inc;
                        s_d.bit_cnt = CNT_RST;
                        if (s_q.m_ack) begin
                            s_d.st = ST_RDATA;
                            s_d.oe = ~nx_byte[BYTE_W-1]; // see R6
                        end else begin
                            s_d.st  = ST_IDLE;
                            s_d.sel = 1'b0;
                        end
                    end
                end
                default: begin
                    s_d.st = ST_IDLE;
                    s_d.oe = 1'b0;
                end
            endcase
        end
    end

    // Array is cleared at reset; a real part would keep its contents
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_q          <= '0;
            s_q.st       <= ST_IDLE;
            s_q.scl_prev <= 1'b1;
            s_q.sda_prev <= 1'b1;
            s_q.addr     <= ADDR_RST;
            s_q.shreg    <= BYTE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Open-drain: only ever drive low, see R4
    assign sda_o    = 1'b0;
    assign sda_oe   = s_q.oe;
    assign selected = s_q.sel;

endmodule

// File: see_pkg.sv
/*
 Constants, state codes and the register image of the two-wire memory slave.
 Assumes a 20 MHz system clock that oversamples the serial clock pin.
*/
package see_pkg;

    // System clock
    localparam int unsigned CLK_PERIOD_NS = 50;

    // Array and identifier geometry
    localparam int unsigned MEM_DEPTH     = 256;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned ID_BYTES      = 16;
    localparam int unsigned ID_IDX_W      = 4;
    localparam int unsigned STRAP_W       = 3;
    localparam int unsigned SYNC_W        = 6;
    localparam int unsigned CNT_W         = 4;

    // Field positions in the first byte after a start
    localparam int unsigned PFX_MSB       = 7;
    localparam int unsigned PFX_LSB       = 4;
    localparam int unsigned STRAP_MSB     = 3;
    localparam int unsigned STRAP_LSB     = 1;
    localparam int unsigned RW_BIT        = 0;

    // Device-type prefixes: user array and identifier space
    localparam logic [3:0] MEM_PREFIX     = 4'hA;
    localparam logic [3:0] ID_PREFIX      = 4'hB;

    // Bit counter value once a whole byte has been clocked
    localparam logic [CNT_W-1:0] BIT_LAST = 4'h8;
    localparam logic [CNT_W-1:0] CNT_RST  = 4'h0;

    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

    // Protocol states, one-hot
    typedef enum logic [8:0] {
        ST_IDLE      = 9'h001,
        ST_ADDR      = 9'h002,
        ST_ADDR_ACK  = 9'h004,
        ST_WORD      = 9'h008,
        ST_WORD_ACK  = 9'h010,
        ST_WDATA     = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA     = 9'h080,
        ST_MACK      = 9'h100
    } see_state_e_t;

    typedef logic [MEM_DEPTH-1:0][BYTE_W-1:0] see_mem_t;
    typedef logic [ID_BYTES-1:0][BYTE_W-1:0]  see_id_t;

    // Whole state of the slave
    typedef struct packed {
        see_state_e_t        st;
        logic                scl_prev;
        logic                sda_prev;
        logic [CNT_W-1:0]    bit_cnt;
        logic [BYTE_W-1:0]   shreg;
        logic [ADDR_W-1:0]   addr;
        logic                id_sel;
        logic                rw;
        logic                m_ack;
        logic                oe;
        logic                sel;
        see_mem_t            mem;
    } see_state_t;

endpackage

// File: see_sync.sv
/*
 Two-flop synchroniser for a group of pin inputs.
 Assumes asynchronous pins; the first stage feeds only the second.
*/
`timescale 1ns/1ps
module see_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } see_sync_t;

    see_sync_t s_q;
    see_sync_t s_d;

    // Stage shift
    always_comb begin
        s_d        = s_q;
        s_d.meta   = d;
        s_d.stable = s_q.meta;
    end

    // Reset to low, as the pad pull-downs would leave an open pin
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.stable;

endmodule

// File: see_monitor.sv
/*
 Port checker for the two-wire memory slave, bound to see_slave.
 Assumes the serial pins change away from system clock edges.
*/
`timescale 1ns/1ps
module see_monitor (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic chip_select_strap_0,
    input wire logic chip_select_strap_1,
    input wire logic chip_select_strap_2,
    input wire logic write_lock,
    input wire logic selected
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Wire level and drive timing
    property p_od; sda_o == 1'b0; endproperty
    property p_fall; $changed(sda_oe) |-> !$past(scl, 1) && !$past(scl, 2); endproperty
    property p_high; $rose(scl) |=> $stable(sda_oe) [*3]; endproperty
    property p_idle; scl [*8] |-> !sda_oe; endproperty
    property p_bound; $rose(sda_oe) |-> ##[1:100] !sda_oe; endproperty
    // Selection and passivity
    property p_sel; $rose(selected) |-> ##[0:2] sda_oe; endproperty
    property p_pass; sda_oe && $past(sda_oe) |-> selected; endproperty
    property p_drop; $fell(selected) |-> !sda_oe; endproperty

    a_od: assert property (p_od) else $error("data value pin not low");
    a_fall: assert property (p_fall) else $error("drive changed outside clock low");
    a_high: assert property (p_high) else $error("drive changed while clock high");
    a_idle: assert property (p_idle) else $error("data pulled on idle bus");
    a_bound: assert property (p_bound) else $error("data held low too long");
    a_sel: assert property (p_sel) else $error("selected without acknowledge");
    a_pass: assert property (p_pass) else $error("driving while not selected");
    a_drop: assert property (p_drop) else $error("still driving after deselect");

    // Main scenarios reached
    c_sel: cover property ($rose(selected));
    c_lock: cover property (write_lock && selected);
    c_read: cover property (selected && sda_oe && scl);
endmodule

bind see_slave see_monitor i_mon (.clock(clock), .arst_n(arst_n), .scl(scl), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_strap_0(chip_select_strap_0),
    .chip_select_strap_1(chip_select_strap_1), .chip_select_strap_2(chip_select_strap_2),
    .write_lock(write_lock), .selected(selected));

// File: see_master.sv
/*
 Two-wire bus master model: drives the clock and pulls the data wire low.
 Assumes the bench resolves the data wire with a pull-up; 400 ns bit time.
*/
`timescale 1ns/1ps
module see_master (
    output logic      scl,
    output logic      m_oe,
    input  wire logic sda
);
    // Idle bus: clock parked high, data released
    initial begin
        scl  = 1'b1;
        m_oe = 1'b0;
    end

    // One bit: set while clock low, sampled in the middle of high
    task automatic bit_io(input logic b, output logic r);
        m_oe = ~b;
        #100 scl = 1'b1;
        #100 r = sda;
        #100 scl = 1'b0;
        #100;
    endtask

    // Start, also usable as repeated start after a low clock
    task automatic start();
        m_oe = 1'b0;
        #100 scl = 1'b1;
        #100 m_oe = 1'b1;
        #100 scl = 1'b0;
        #100;
    endtask

    // Stop leaves the clock high for the idle bus
    task automatic stop();
        m_oe = 1'b1;
        #100 scl = 1'b1;
        #100 m_oe = 1'b0;
        #200;
    endtask

    // Byte out MSB first, byte in, then the ninth clock
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(last, r);
        ack = ~r;
    endtask
endmodule

// File: see_slave_tb.sv
/*
 Self-checking bench for see_slave with a bus master model.
 Assumes pull-up on data and pull-downs modelled by driving straps low.
*/
`timescale 1ns/1ps
module see_slave_tb;
    import see_pkg::*;
    localparam logic [127:0] ID_TB = 128'h00112233445566778899AABBCCDDEEFF; // Arbitrary
    localparam logic [2:0]   STRAP = 3'h5;
    logic       clock, arst_n, scl, m_oe, sda, sda_o, sda_oe, write_lock, selected, a;
    logic [2:0] strap;
    logic [7:0] q;
    int         n_errors, comparisons;

    // Open-drain wire with pull-up
    assign sda = ~m_oe & (sda_oe ? sda_o : 1'b1);

    see_slave #(.ID_VALUE(ID_TB)) i_dut (.clock(clock), .arst_n(arst_n), .scl(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_strap_0(strap[0]),
        .chip_select_strap_1(strap[1]), .chip_select_strap_2(strap[2]),
        .write_lock(write_lock), .selected(selected));
    see_master i_mst (.scl(scl), .m_oe(m_oe), .sda(sda));

    // 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Start plus address byte, acknowledge judged
    task automatic hdr(input logic [3:0] p, input logic [2:0] s, input logic rw, input logic e);
        i_mst.start();
        i_mst.xfer({p, s, rw}, 1'b1, q, a);
        chk({7'h00, a}, {7'h00, e});
        chk({7'h00, selected}, {7'h00, e});
    endtask

    task automatic wr(input logic [3:0] p, input logic [7:0] w, input logic [7:0] d,
                      input logic e);
        hdr(p, STRAP, 1'b0, 1'b1);
        i_mst.xfer(w, 1'b1, q, a);
        chk({7'h00, a}, 8'h01);
        i_mst.xfer(d, 1'b1, q, a);
        chk({7'h00, a}, {7'h00, e});
        i_mst.stop();
    endtask

    // Random read of two bytes, master NACK ends it
    task automatic rd(input logic [3:0] p, input logic [7:0] w, input logic [15:0] e);
        hdr(p, STRAP, 1'b0, 1'b1);
        i_mst.xfer(w, 1'b1, q, a);
        hdr(p, STRAP, 1'b1, 1'b1);
        i_mst.xfer(8'hFF, 1'b0, q, a);
        chk(q, e[15:8]);
        i_mst.xfer(8'hFF, 1'b1, q, a);
        chk(q, e[7:0]);
        i_mst.stop();
    endtask

    // Every strap code and a foreign prefix; only the match answers
    task automatic t_select();
        for (int s = 0; s < 8; s++) begin
            hdr(MEM_PREFIX, 3'(s), 1'b0, 3'(s) == STRAP);
            i_mst.stop();
            chk({7'h00, selected}, 8'h00);
        end
        hdr(4'h5, STRAP, 1'b0, 1'b0);
        i_mst.stop();
    endtask

    // Writes, sequential read back, and wrap from the last location
    task automatic t_write();
        wr(MEM_PREFIX, 8'h10, 8'h5A, 1'b1);
        wr(MEM_PREFIX, 8'h11, 8'hC3, 1'b1);
        rd(MEM_PREFIX, 8'h10, 16'h5AC3);
        wr(MEM_PREFIX, 8'hFF, 8'h96, 1'b1);
        rd(MEM_PREFIX, 8'hFF, 16'h9600);
    endtask

    // Lock high: data refused, contents kept
    task automatic t_lock();
        @(posedge clock);
        #1 write_lock = 1'b1;
        wr(MEM_PREFIX, 8'h10, 8'hFF, 1'b0);
        rd(MEM_PREFIX, 8'h10, 16'h5AC3);
        @(posedge clock);
        #1 write_lock = 1'b0;
    endtask

    // Identifier: write refused, value read, array untouched
    task automatic t_ident();
        wr(ID_PREFIX, 8'h00, 8'h55, 1'b0);
        rd(ID_PREFIX, 8'h00, {ID_TB[7:0], ID_TB[15:8]});
        rd(MEM_PREFIX, 8'h00, 16'h0000);
    endtask

    // Straps left floating read as low
    task automatic t_pulldown();
        @(posedge clock);
        #1 strap = 3'h0;
        hdr(MEM_PREFIX, 3'h0, 1'b0, 1'b1);
        i_mst.stop();
        @(posedge clock);
        #1 strap = STRAP;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clock);
        n_errors++;
        test_done();
    end

    // Main sequence
    initial begin
        arst_n     = 1'b0;
        write_lock = 1'b0;
        strap      = STRAP;
        n_errors   = 0;
        comparisons = 0;
        repeat (20) @(posedge clock);
        #1 arst_n = 1'b1;
        repeat (4) @(posedge clock);
        // Bus pins move just after an edge, never on it
        #1;
        t_select();
        t_write();
        t_lock();
        t_ident();
        t_pulldown();
        test_done();
    end
endmodule
